// ===== acc_core.sv
// Summary of operation
// - Each filter word is averaged with the previous word to form a result.
// - First result after a start appears only after two update periods.
// - Four calibrations: internal zero, internal full, system zero, system full.
// - Reset loads factory offset and gain coefficients for both converters.
// - Calibration updates coefficients only of converters enabled in mode register.
// - Each converter owns separate offset and gain coefficient registers.
// - Zero-scale calibration stores its result as the offset coefficient.
// - Full-scale calibration stores its result as the gain coefficient.
// - Internal calibration routes internal zero or full-scale to converter input.
// - Calibration conversions always run at the slowest update rate.
// - Correction subtracts the offset, then multiplies by the normalised gain.
// - Calibration end sets the converter ready flag, as for a conversion.
// - Missing reference during calibration blocks the update and sets error.
`timescale 1ns/1ps
module acc_core #(
  parameter logic [23:0] FACTORY_OFS0 = 24'h000000, // Arbitrary factory value
  parameter logic [23:0] FACTORY_GAIN0 = 24'h800000, // Arbitrary factory value
  parameter logic [23:0] FACTORY_OFS1 = 24'h000000, // Arbitrary factory value
  parameter logic [23:0] FACTORY_GAIN1 = 24'h800000 // Arbitrary factory value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [acc_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic flt0_valid,
  input wire logic [acc_pkg::DW-1:0] flt0_data,
  input wire logic flt1_valid,
  input wire logic [acc_pkg::DW-1:0] flt1_data,
  input wire logic ref_missing_pin,
  output logic irq,
  output logic [1:0] route0,
  output logic [1:0] route1,
  output logic [7:0] filter_rate,
  output logic [1:0] mod_run,
  output logic filter_restart
);
  import acc_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  acc_state_t state_q;
  logic [2:0] mode_q;
  logic [1:0] en_q;
  logic [7:0] rate_reg_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] ien_q;
  logic [NEV-1:0] ev;
  logic [1:0] cal_pend_q;
  logic [1:0] cal_sel_q;
  logic [1:0] have_prev_q;
  logic [1:0] noref_seen_q;
  logic [1:0] active;
  logic [1:0] res_evt;
  logic [1:0] flt_valid;
  logic [DW-1:0] flt_data [2];
  logic [DW-1:0] prev_q [2];
  logic [DW-1:0] avg [2];
  logic [DW:0] pair_sum [2];
  logic [DW-1:0] data_q [2];
  logic [DW-1:0] ofs_q [2];
  logic [DW-1:0] gain_q [2];
  logic [1:0] route_q [2];
  logic nr_s1_q, nr_s2_q, nr_s3_q, noref_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [7:0] rate_q;
  logic [1:0] run_q;
  logic restart_q;
  logic mode_wr;
  logic restart;
  logic cal_zero;
  logic cal_int;
  logic cal_finish;
  logic [2:0] wr_mode;

  // Offset removal, normalised gain, saturation to the data width
  function automatic logic [DW-1:0] acc_correct(input logic [DW-1:0] x,
                                                input logic [DW-1:0] ofs,
                                                input logic [DW-1:0] gain);
    logic signed [DW:0] diff;
    logic signed [2*DW+1:0] prod;
    logic signed [2*DW+1:0] s;
    diff = $signed({x[DW-1], x}) - $signed({ofs[DW-1], ofs});
    prod = diff * $signed({1'b0, gain});
    s = prod >>> GAIN_FRAC;
    if (&s[2*DW+1:DW-1] || ~|s[2*DW+1:DW-1]) begin
      acc_correct = s[DW-1:0];
    end else begin
      acc_correct = s[2*DW+1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end
  endfunction : acc_correct

  // --------------------------------------------------------------------------
  // Input gathering and decode
  // --------------------------------------------------------------------------
  assign flt_valid = {flt1_valid, flt0_valid};
  assign flt_data[0] = flt0_data;
  assign flt_data[1] = flt1_data;
  assign wr_mode = reg_wdata[MODE_LSB +: 3];
  assign mode_wr = reg_wr && (reg_addr == ADDR_MODE);
  assign restart = mode_wr && (wr_mode != MODE_IDLE);
  assign cal_zero = (mode_q == MODE_INT_ZERO) || (mode_q == MODE_SYS_ZERO);
  assign cal_int = (mode_q == MODE_INT_ZERO) || (mode_q == MODE_INT_FULL);
  assign cal_finish = (state_q == ST_CAL) && ((cal_pend_q & ~res_evt) == 2'h0);

  // Active converters and result events
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      active[i] = ((state_q == ST_CONV) && en_q[i]) || ((state_q == ST_CAL) && cal_pend_q[i]);
      res_evt[i] = flt_valid[i] && active[i] && have_prev_q[i] && !restart;
      pair_sum[i] = {prev_q[i][DW-1], prev_q[i]} + {flt_data[i][DW-1], flt_data[i]};
      avg[i] = pair_sum[i][DW:1];
    end
  end

  // Sticky events: ready on result or calibration end, error on missing reference during calibration
  always_comb begin
    ev = '0;
    for (int i = 0; i < 2; i++) begin
      ev[ST_PRIMARY_RESULT_READY_FLAG + i] = res_evt[i];
      ev[ST_PRIMARY_CALIBRATION_ERROR_FLAG + i] = res_evt[i] && (state_q == ST_CAL) && (noref_seen_q[i] || noref_q);
    end
  end

  // --------------------------------------------------------------------------
  // Missing reference synchroniser
  // --------------------------------------------------------------------------
  // Three stages; the level moves once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nr_s1_q <= 1'b0;
      nr_s2_q <= 1'b0;
      nr_s3_q <= 1'b0;
      noref_q <= 1'b0;
    end else begin
      nr_s1_q <= ref_missing_pin;
      nr_s2_q <= nr_s1_q;
      nr_s3_q <= nr_s2_q;
      if (nr_s2_q == nr_s3_q) begin
        noref_q <= nr_s3_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  // Mode, rate and interrupt enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_IDLE;
      en_q <= 2'h0;
      rate_reg_q <= RATE_RST;
      ien_q <= IEN_RST;
    end else begin
      if (cal_finish) begin
        mode_q <= MODE_IDLE;
      end
      if (mode_wr) begin
        mode_q <= wr_mode;
        en_q <= reg_wdata[EN_LSB +: 2];
      end
      if (reg_wr && (reg_addr == ADDR_RATE)) begin
        rate_reg_q <= reg_wdata[7:0];
      end
      if (reg_wr && (reg_addr == ADDR_IEN)) begin
        ien_q <= reg_wdata[NEV-1:0];
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else if (reg_wr && (reg_addr == ADDR_ICLR)) begin
      stat_q <= (stat_q & ~reg_wdata[NEV-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Read data, valid in the cycle after the read strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_MODE: rdata_q <= 32'({en_q, 1'b0, mode_q});
        ADDR_RATE: rdata_q <= 32'(rate_reg_q);
        ADDR_STAT: rdata_q <= 32'({state_q == ST_CAL, noref_q, stat_q});
        ADDR_IEN: rdata_q <= 32'(ien_q);
        ADDR_DATA0: rdata_q <= 32'(data_q[0]);
        ADDR_DATA1: rdata_q <= 32'(data_q[1]);
        ADDR_OFS0: rdata_q <= 32'(ofs_q[0]);
        ADDR_GAIN0: rdata_q <= 32'(gain_q[0]);
        ADDR_OFS1: rdata_q <= 32'(ofs_q[1]);
        ADDR_GAIN1: rdata_q <= 32'(gain_q[1]);
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Idle, converting or calibrating; calibration ends back in idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cal_pend_q <= 2'h0;
      cal_sel_q <= 2'h0;
    end else if (mode_wr) begin
      cal_sel_q <= reg_wdata[EN_LSB +: 2];
      cal_pend_q <= wr_mode[2] ? reg_wdata[EN_LSB +: 2] : 2'h0;
      if (wr_mode[2]) begin
        state_q <= ST_CAL;
      end else if (wr_mode == MODE_CONV) begin
        state_q <= ST_CONV;
      end else begin
        state_q <= ST_IDLE;
      end
    end else begin
      cal_pend_q <= cal_pend_q & ~res_evt;
      if (cal_finish) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Chop averaging and result path
  // --------------------------------------------------------------------------
  // Previous filter word per converter; its valid flag cleared on every start, word kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        prev_q[i] <= '0;
        have_prev_q[i] <= 1'b0;
        noref_seen_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (restart) begin
          have_prev_q[i] <= 1'b0;
          noref_seen_q[i] <= 1'b0;
        end else begin
          if (flt_valid[i] && active[i]) begin
            prev_q[i] <= flt_data[i];
            have_prev_q[i] <= 1'b1;
          end
          if ((state_q == ST_CAL) && cal_pend_q[i] && noref_q) begin
            noref_seen_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Corrected results; all ones while the reference is missing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 2; i++) begin
        data_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (res_evt[i] && (state_q == ST_CONV)) begin
          data_q[i] <= noref_q ? {DW{1'b1}} : acc_correct(avg[i], ofs_q[i], gain_q[i]);
        end
      end
    end
  end

  // Coefficients: factory values at reset, calibration results later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ofs_q[0] <= FACTORY_OFS0;
      gain_q[0] <= FACTORY_GAIN0;
      ofs_q[1] <= FACTORY_OFS1;
      gain_q[1] <= FACTORY_GAIN1;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (res_evt[i] && (state_q == ST_CAL) && !ev[ST_PRIMARY_CALIBRATION_ERROR_FLAG + i]) begin
          if (cal_zero) begin
            ofs_q[i] <= avg[i];
          end else begin
            gain_q[i] <= avg[i];
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Modulator and filter controls
  // --------------------------------------------------------------------------
  // Input routing, update rate, run enables, restart pulse, interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      route_q[0] <= ROUTE_EXT;
      route_q[1] <= ROUTE_EXT;
      rate_q <= RATE_RST;
      run_q <= 2'h0;
      restart_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((state_q == ST_CAL) && cal_pend_q[i] && cal_int) begin
          route_q[i] <= cal_zero ? ROUTE_ZERO : ROUTE_FULL;
        end else begin
          route_q[i] <= ROUTE_EXT;
        end
      end
      rate_q <= (state_q == ST_CAL) ? RATE_SLOW : rate_reg_q;
      run_q <= active;
      restart_q <= restart;
      irq_q <= |(stat_q & ien_q);
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign route0 = route_q[0];
  assign route1 = route_q[1];
  assign filter_rate = rate_q;
  assign mod_run = run_q;
  assign filter_restart = restart_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_avg_value: assert property (res_evt[0] && (state_q == ST_CONV) && !noref_q |=>
    data_q[0] == acc_correct($past(avg[0]), ofs_q[0], gain_q[0]))
    else $error("result is not the corrected chop average");

  a_first_result: assert property (restart |=> !res_evt[0] && !res_evt[1])
    else $error("result produced without a previous filter word");

  a_cal_rate: assert property ((state_q == ST_CAL) |=> filter_rate == RATE_SLOW)
    else $error("calibration not at slowest rate");

  a_route_int: assert property ((state_q == ST_CAL) && cal_int && cal_pend_q[0] |=>
    route0 == ($past(cal_zero) ? ROUTE_ZERO : ROUTE_FULL))
    else $error("internal calibration input not routed");

  a_coef_hold: assert property ((state_q == ST_CAL) && !cal_sel_q[1] && !mode_wr |=>
    $stable(ofs_q[1]) && $stable(gain_q[1]))
    else $error("disabled converter coefficients changed");

  a_ofs_store: assert property (res_evt[0] && (state_q == ST_CAL) && cal_zero &&
    !noref_q && !noref_seen_q[0] |=> ofs_q[0] == $past(avg[0]) && $stable(gain_q[0]))
    else $error("offset not stored from zero-scale result");

  a_gain_store: assert property (res_evt[1] && (state_q == ST_CAL) && !cal_zero &&
    !noref_q && !noref_seen_q[1] |=> gain_q[1] == $past(avg[1]) && $stable(ofs_q[1]))
    else $error("gain not stored from full-scale result");

  a_noref_block: assert property (res_evt[0] && (state_q == ST_CAL) && noref_q |=>
    stat_q[ST_PRIMARY_CALIBRATION_ERROR_FLAG] && $stable(ofs_q[0]) && $stable(gain_q[0]))
    else $error("coefficients updated without a reference");

  a_cal_ready: assert property (res_evt[1] && (state_q == ST_CAL) |=> stat_q[ST_AUXILIARY_RESULT_READY_FLAG])
    else $error("calibration end did not set ready");

  a_idle_return: assert property (cal_finish && !mode_wr |=>
    (state_q == ST_IDLE) && (mode_q == MODE_IDLE) ##1 !mod_run[0] && !mod_run[1])
    else $error("calibration did not return to idle");

  c_conv_result: cover property ((state_q == ST_CONV) && res_evt[0]);
  c_zero_cal: cover property ((state_q == ST_CAL) && cal_zero && res_evt[0] ##1 state_q == ST_IDLE);
  c_full_cal_err: cover property ((state_q == ST_CAL) && !cal_zero && ev[ST_AUXILIARY_CALIBRATION_ERROR_FLAG]);
  c_irq: cover property ($rose(irq));

endmodule : acc_core

// ===== acc_core_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Register level bench
// ----------------------------------------
module acc_core_test;
  import acc_pkg::*;
  localparam logic [23:0] ZW = 24'h000020;
  localparam logic [23:0] FW = 24'h7ff000;
  localparam logic [23:0] SZ = 24'h000100;
  localparam logic [23:0] SF = 24'h400000;
  logic clk, rstn, reg_wr, reg_rd, ref_missing_pin;
  logic flt0_valid, flt1_valid, irq, filter_restart;
  logic [7:0] reg_addr, filter_rate;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [23:0] flt0_data, flt1_data, ext0;
  logic [1:0] route0, route1, mod_run;
  int n0, n1, n_mismatch, total_checks, cyc, i, k;
  logic [2:0] md[4] = '{MODE_INT_ZERO, MODE_INT_FULL, MODE_SYS_ZERO, MODE_SYS_FULL};
  logic [23:0] xt[4] = '{24'h0abcde, 24'h0abcde, SZ, SF};
  logic [23:0] ex[4] = '{ZW, FW, SZ, SF};
  logic [7:0] ad[4] = '{ADDR_OFS0, ADDR_GAIN0, ADDR_OFS0, ADDR_GAIN0};
  logic [1:0] rt[4] = '{ROUTE_ZERO, ROUTE_FULL, ROUTE_EXT, ROUTE_EXT};

  acc_core DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flt0_valid, .flt0_data, .flt1_valid, .flt1_data, .ref_missing_pin, .irq,
    .route0, .route1, .filter_rate, .mod_run, .filter_restart);
  acc_flt_model #(.ZERO_WORD(ZW), .FULL_WORD(FW)) m0 (.clk, .rstn, .route(route0),
    .rate(filter_rate), .run(mod_run[0]), .restart(filter_restart), .ext_word(ext0),
    .valid(flt0_valid), .data(flt0_data), .nwords(n0));
  acc_flt_model #(.ZERO_WORD(ZW), .FULL_WORD(FW)) m1 (.clk, .rstn, .route(route1),
    .rate(filter_rate), .run(mod_run[1]), .restart(filter_restart),
    .ext_word(24'h000333), .valid(flt1_valid), .data(flt1_data), .nwords(n1));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Single cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read; data stand in the following cycle only
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rd_v, e);
  endtask : rchk

  // Poll a status bit, bounded
  task automatic wait_st(input int b);
    int j;
    for (j = 0; j < 900; j++) begin
      rd(ADDR_STAT);
      if (rd_v[b] === 1'b1) break;
    end
  endtask : wait_st

  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ref_missing_pin = 1'b0;
    ext0 = 24'h012345;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rchk("mode", ADDR_MODE, 32'h0);
    rchk("rate", ADDR_RATE, 32'h45);
    rchk("ofs0", ADDR_OFS0, 32'h0);
    rchk("gain0", ADDR_GAIN0, 32'h800000);
    rchk("ofs1", ADDR_OFS1, 32'h0);
    rchk("gain1", ADDR_GAIN1, 32'h800000);
    rchk("unmapped", 8'h40, 32'h0);
    // Conversion on both, interrupt masked
    wr(ADDR_MODE, 32'h31);
    for (i = 0; i < 400 && n0 < 1; i++) @(posedge clk);
    rd(ADDR_STAT);
    chk("primary_result_ready_flag early", {31'h0, rd_v[ST_PRIMARY_RESULT_READY_FLAG]}, 32'h0);
    wait_st(ST_PRIMARY_RESULT_READY_FLAG);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rchk("data0", ADDR_DATA0, 32'h012345);
    rchk("data1", ADDR_DATA1, 32'h000333);
    wr(ADDR_MODE, 32'h0);
    // Four calibrations of the primary converter, zero-scale ahead of full-scale
    for (k = 0; k < 4; k++) begin
      ext0 <= xt[k];
      wr(ADDR_ICLR, 32'hf);
      wr(ADDR_MODE, 32'h10 | {29'h0, md[k]});
      repeat (2) @(posedge clk);
      #1 chk("route0", {30'h0, route0}, {30'h0, rt[k]});
      chk("cal rate", {24'h0, filter_rate}, {24'h0, RATE_SLOW});
      wait_st(ST_PRIMARY_RESULT_READY_FLAG);
      chk("cal primary_result_ready_flag", {31'h0, rd_v[ST_PRIMARY_RESULT_READY_FLAG]}, 32'h1);
      rchk("coef", ad[k], {8'h0, ex[k]});
      rd(ADDR_MODE);
      chk("mode idle", {29'h0, rd_v[2:0]}, 32'h0);
      chk("route back", {30'h0, route0}, 32'h0);
    end
    rchk("ofs1 kept", ADDR_OFS1, 32'h0);
    rchk("gain1 kept", ADDR_GAIN1, 32'h800000);
    // Calibration with reference missing
    ref_missing_pin <= 1'b1;
    wr(ADDR_ICLR, 32'hf);
    wr(ADDR_MODE, 32'h14);
    wait_st(ST_PRIMARY_RESULT_READY_FLAG);
    chk("primary_calibration_error_flag", {31'h0, rd_v[ST_PRIMARY_CALIBRATION_ERROR_FLAG]}, 32'h1);
    chk("noref live", {31'h0, rd_v[ST_NOREF]}, 32'h1);
    rchk("ofs0 kept", ADDR_OFS0, {8'h0, SZ});
    ref_missing_pin <= 1'b0;
    // Corrected conversion with interrupt enabled
    ext0 <= 24'h001100;
    wr(ADDR_ICLR, 32'hf);
    wr(ADDR_IEN, 32'h1);
    wr(ADDR_MODE, 32'h11);
    wait_st(ST_PRIMARY_RESULT_READY_FLAG);
    rchk("data0 corr", ADDR_DATA0, 32'h000800);
    chk("irq on", {31'h0, irq}, 32'h1);
    // Internal full-scale calibration of the auxiliary converter alone
    wr(ADDR_MODE, 32'h20 | {29'h0, MODE_INT_FULL});
    #1 chk("restart", {31'h0, filter_restart}, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("route1", {30'h0, route1}, {30'h0, ROUTE_FULL});
    wait_st(ST_AUXILIARY_RESULT_READY_FLAG);
    chk("cal auxiliary_result_ready_flag", {31'h0, rd_v[ST_AUXILIARY_RESULT_READY_FLAG]}, 32'h1);
    rchk("gain1 cal", ADDR_GAIN1, {8'h0, FW});
    rchk("ofs1 same", ADDR_OFS1, 32'h0);
    rchk("gain0 same", ADDR_GAIN0, {8'h0, SF});
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_ICLR, 32'hf);
    repeat (2) @(posedge clk);
    #1 chk("irq off", {31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : acc_core_test

// ===== acc_flt_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Chopped filter word source, one converter
// ----------------------------------------
module acc_flt_model #(
  parameter logic [23:0] ZERO_WORD = 24'h000020,
  parameter logic [23:0] FULL_WORD = 24'h7ff000,
  parameter logic [23:0] CHOP = 24'h000010
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] route,
  input wire logic [7:0] rate,
  input wire logic run,
  input wire logic restart,
  input wire logic [acc_pkg::DW-1:0] ext_word,
  output logic valid,
  output logic [acc_pkg::DW-1:0] data,
  output int nwords
);
  import acc_pkg::*;
  logic [7:0] cnt_q;
  logic pol_q;
  logic [DW-1:0] lvl;

  // Level at the modulator input
  always_comb begin
    case (route)
      ROUTE_ZERO: lvl = ZERO_WORD;
      ROUTE_FULL: lvl = FULL_WORD;
      default: lvl = ext_word;
    endcase
  end

  // One word per update period, sign of chop flips; junk between words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      pol_q <= 1'b0;
      valid <= 1'b0;
      data <= '0;
      nwords <= 0;
    end else if (restart) begin
      cnt_q <= 8'h00;
      pol_q <= 1'b0;
      valid <= 1'b0;
      nwords <= 0;
    end else if (run && cnt_q >= rate) begin
      cnt_q <= 8'h00;
      valid <= 1'b1;
      data <= pol_q ? lvl - CHOP : lvl + CHOP;
      pol_q <= ~pol_q;
      nwords <= nwords + 1;
    end else begin
      cnt_q <= run ? cnt_q + 8'h01 : 8'h00;
      valid <= 1'b0;
      data <= ~data;
    end
  end
endmodule : acc_flt_model

// ===== acc_pkg.sv
// ----------------------------------------------------------------------------
// Converter chop averaging and calibration: shared constants
// ----------------------------------------------------------------------------
package acc_pkg;

  // Widths
  localparam int AW = 8;
  localparam int DW = 24;
  localparam int GAIN_FRAC = 23;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ICLR = 8'h0c;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  localparam logic [7:0] ADDR_DATA0 = 8'h14;
  localparam logic [7:0] ADDR_DATA1 = 8'h18;
  localparam logic [7:0] ADDR_OFS0 = 8'h1c;
  localparam logic [7:0] ADDR_GAIN0 = 8'h20;
  localparam logic [7:0] ADDR_OFS1 = 8'h24;
  localparam logic [7:0] ADDR_GAIN1 = 8'h28;

  // Mode register fields
  localparam int MODE_LSB = 0;
  localparam int EN_LSB = 4;

  // Mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONV = 3'h1;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;

  // Status bit positions (bits 0..3 are sticky events)
  localparam int ST_PRIMARY_RESULT_READY_FLAG = 0;
  localparam int ST_AUXILIARY_RESULT_READY_FLAG = 1;
  localparam int ST_PRIMARY_CALIBRATION_ERROR_FLAG = 2;
  localparam int ST_AUXILIARY_CALIBRATION_ERROR_FLAG = 3;
  localparam int ST_NOREF = 4;
  localparam int ST_BUSY = 5;
  localparam int NEV = 4;

  // Input routing codes toward the modulator
  localparam logic [1:0] ROUTE_EXT = 2'h0;
  localparam logic [1:0] ROUTE_ZERO = 2'h1;
  localparam logic [1:0] ROUTE_FULL = 2'h2;

  // Reset values and rates
  localparam logic [7:0] RATE_RST = 8'h45;
  localparam logic [7:0] RATE_SLOW = 8'hff;
  localparam logic [NEV-1:0] IEN_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CAL = 3'b100
  } acc_state_t;

endpackage : acc_pkg
